// [rtl/ssq_pkg.sv]
// constants and carrier types for the single sweep sequencer
package ssq_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // converter_control_zero
  localparam logic [7:0] OFF_INSEL  = 8'h04;  // input_select_register
  localparam logic [7:0] OFF_IRQST  = 8'h08;  // sticky event status
  localparam logic [7:0] OFF_IRQMSK = 8'h0C;  // event mask
  localparam logic [7:0] OFF_STATE  = 8'h10;  // sequencer state
  localparam logic [7:0] OFF_RES0   = 8'h20;  // first result register
  localparam logic [7:0] OFF_RESEND = 8'h3C;  // last result register
  // control register fields
  localparam int CTRL_START = 0;              // conversion_start_flag
  localparam int CTRL_SRC_LO = 1;             // start source, 2 bits
  localparam int CTRL_RES10 = 3;              // 1: 10-bit results
  // input select fields
  localparam int INSEL_CNT_LO = 0;            // sweep_count_field, 2 bits
  localparam int INSEL_GRP_LO = 2;            // group_select_field, 2 bits
  // event bits
  localparam int EV_DONE  = 0;                // sweep completed
  localparam int EV_ABORT = 1;                // sweep aborted by software
  localparam int EV_W     = 2;
  // widths and reset values
  localparam int RES_W  = 10;                 // result width
  localparam int NRES   = 8;                  // result registers
  localparam int CH_W   = 4;                  // analog input index width
  localparam logic [3:0] CTRL_RST  = 4'h0;
  localparam logic [3:0] INSEL_RST = 4'h0;
  localparam logic [3:0] HIGH_BANK = 4'h8;    // first input of upper bank
  // start sources
  typedef enum logic [1:0] {
    SRC_SW    = 2'h0,
    SRC_TMR_A = 2'h1,
    SRC_TMR_B = 2'h2,
    SRC_EXT   = 2'h3
  } ssq_src_t;
  // request to the converter core
  typedef struct packed {
    logic            start;                   // one-cycle start pulse
    logic [CH_W-1:0] chan;                    // analog input to sample
    logic            res10;                   // 10-bit resolution
  } ssq_conv_req_t;
  // answer from the converter core
  typedef struct packed {
    logic             done;                   // one-cycle completion pulse
    logic [RES_W-1:0] data;                   // 10-bit raw code
  } ssq_conv_rsp_t;
endpackage

// [rtl/ssq_sweep_seq.sv]
// single sweep sequencer with register port, triggers and interrupt
// What this block does
// - converts each selected input once per sweep
// - group from group and count fields
// - start by software, timers or external trigger
// - software sweep clears start flag when done
// - interrupt when whole group is converted
// - result stored at input index modulo eight
// - clearing start flag aborts with the abort event instead of done
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ssq_sweep_seq #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [DATA_W-1:0]     wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [DATA_W-1:0]     rdata_out,
  input  wire logic                  tmr_a_trig_in,
  input  wire logic                  tmr_b_trig_in,
  input  wire logic                  ext_trig_in,
  output ssq_pkg::ssq_conv_req_t     conv_req_out,
  input  wire ssq_pkg::ssq_conv_rsp_t conv_rsp_in,
  output logic                       irq_out
);

  // number of inputs in a sweep minus one, from the count field
  // count codes 0 to 3 give 2, 4, 6 or 8 inputs
  function automatic logic [2:0] last_pos(input logic [1:0] cnt);
    last_pos = {cnt, 1'b1};
  endfunction

  // sequencer states, one-hot
  // launch and wait alternate once per input
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,  // stopped
    ST_ARMED = 4'b0010,  // waiting for a hardware trigger
    ST_LAUNCH = 4'b0100, // issue start for current input
    ST_WAIT  = 4'b1000   // conversion running
  } ssq_state_t;

  ssq_state_t                      state_reg;     // current state
  ssq_state_t                      state_next;    // next state
  logic                            start_reg;     // conversion_start_flag
  logic                            start_next;
  logic [1:0]                      src_reg;       // start source
  logic                            res10_reg;     // resolution select
  logic [1:0]                      cnt_reg;       // sweep_count_field
  logic [1:0]                      grp_reg;       // group_select_field
  logic [2:0]                      pos_reg;       // position in sweep
  logic [2:0]                      pos_next;
  logic [ssq_pkg::EV_W-1:0]        evst_reg;      // sticky events
  logic [ssq_pkg::EV_W-1:0]        evmsk_reg;     // event mask
  logic [ssq_pkg::RES_W-1:0]       res_reg [ssq_pkg::NRES]; // result_registers
  logic [DATA_W-1:0]               rdata_reg;     // read data
  ssq_pkg::ssq_conv_req_t          req_reg;       // request to core
  logic                            irq_reg;
  logic                            ext_s1_reg;    // external pin sync 1
  logic                            ext_s2_reg;    // external pin sync 2
  logic                            ext_s3_reg;    // delayed for edge

  // register port decode
  // results sit at word aligned offsets only
  wire logic wr_ctrl  = wr_in && (addr_in == ssq_pkg::OFF_CTRL);
  wire logic wr_insel = wr_in && (addr_in == ssq_pkg::OFF_INSEL);
  wire logic wr_evst  = wr_in && (addr_in == ssq_pkg::OFF_IRQST);
  wire logic wr_evmsk = wr_in && (addr_in == ssq_pkg::OFF_IRQMSK);
  wire logic res_hit  = (addr_in >= ssq_pkg::OFF_RES0) && (addr_in <= ssq_pkg::OFF_RESEND)
                        && (addr_in[1:0] == 2'h0);
  wire logic [2:0] res_idx = 3'((addr_in - ssq_pkg::OFF_RES0) >> 2);

  // software start and stop edges on the start flag
  // a set is taken only in idle, a clear only outside idle
  wire logic sw_set   = wr_ctrl && wdata_in[ssq_pkg::CTRL_START];
  wire logic sw_clear = wr_ctrl && !wdata_in[ssq_pkg::CTRL_START];

  // rising edge of the synchronised external trigger
  wire logic ext_edge = ext_s2_reg && !ext_s3_reg;

  // selected hardware trigger
  // timer pulses share our clock, so they skip the synchroniser
  wire logic hw_trig = (src_reg == ssq_pkg::SRC_TMR_A) ? tmr_a_trig_in :
                       (src_reg == ssq_pkg::SRC_TMR_B) ? tmr_b_trig_in :
                       (src_reg == ssq_pkg::SRC_EXT)   ? ext_edge : 1'b0;

  // group base: upper bank only for two or four inputs
  // upper bank with six or eight inputs falls back to the low bank
  wire logic [ssq_pkg::CH_W-1:0] base_ch =
    (grp_reg[0] && !cnt_reg[1]) ? ssq_pkg::HIGH_BANK : '0;
  wire logic [ssq_pkg::CH_W-1:0] cur_ch = base_ch | {1'b0, pos_reg};

  // conversion finished for the current input
  // a late done after an abort finds no wait state and is dropped
  wire logic conv_done = (state_reg == ST_WAIT) && conv_rsp_in.done;
  wire logic sweep_end = conv_done && (pos_reg == last_pos(cnt_reg));

  // start is registered this cycle and reaches the core next cycle, unless software aborts
  wire logic launch_go = (state_reg == ST_LAUNCH) && !sw_clear;

  // result width: 8-bit keeps the top bits, right aligned
  // the core always returns ten bits; narrow mode drops the two lsbs
  wire logic [ssq_pkg::RES_W-1:0] res_val = res10_reg ? conv_rsp_in.data :
    {2'h0, conv_rsp_in.data[ssq_pkg::RES_W-1 -: 8]};

  // events raised this cycle
  wire logic [ssq_pkg::EV_W-1:0] ev_now;
  assign ev_now[ssq_pkg::EV_DONE]  = sweep_end && !sw_clear;
  assign ev_now[ssq_pkg::EV_ABORT] = sw_clear && (state_reg == ST_WAIT || state_reg == ST_LAUNCH);

  // read mux
  // unmapped offsets read as zero
  wire logic [DATA_W-1:0] rd_mux =
    (addr_in == ssq_pkg::OFF_CTRL)   ? DATA_W'({res10_reg, src_reg, start_reg}) :
    (addr_in == ssq_pkg::OFF_INSEL)  ? DATA_W'({grp_reg, cnt_reg}) :
    (addr_in == ssq_pkg::OFF_IRQST)  ? DATA_W'(evst_reg) :
    (addr_in == ssq_pkg::OFF_IRQMSK) ? DATA_W'(evmsk_reg) :
    (addr_in == ssq_pkg::OFF_STATE)  ? DATA_W'({pos_reg, state_reg}) :
    res_hit                          ? DATA_W'(res_reg[res_idx]) : '0;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    start_next = start_reg;
    pos_next   = pos_reg;
    case (state_reg)
      ST_IDLE: begin
        pos_next = 3'h0;
        if (sw_set) begin
          start_next = 1'b1;
          state_next = (wdata_in[ssq_pkg::CTRL_SRC_LO +: 2] == ssq_pkg::SRC_SW) ? ST_LAUNCH : ST_ARMED;
        end
      end
      ST_ARMED: begin
        pos_next = 3'h0;
        if (sw_clear) begin
          start_next = 1'b0;
          state_next = ST_IDLE;
        end else if (hw_trig) begin
          state_next = ST_LAUNCH;
        end
      end
      ST_LAUNCH: begin
        if (sw_clear) begin
          start_next = 1'b0;
          state_next = ST_IDLE;
        end else begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (sw_clear) begin
          start_next = 1'b0;
          state_next = ST_IDLE;
        end else if (sweep_end) begin
          pos_next = 3'h0;
          if (src_reg == ssq_pkg::SRC_SW) begin
            start_next = 1'b0;
            state_next = ST_IDLE;
          end else begin
            // hardware mode rearms for next trigger
            state_next = ST_ARMED;
          end
        end else if (conv_done) begin
          // advance to next input of the group
          pos_next   = 3'(pos_reg + 3'h1);
          state_next = ST_LAUNCH;
        end
      end
      default: begin
        start_next = 1'b0;
        state_next = ST_IDLE;
      end
    endcase
  end

  // state, flag and position
  // a bad state code falls back to idle through the default branch
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      pos_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
      pos_reg   <= pos_next;
    end
  end

  // configuration only taken while stopped
  // writes landing mid-sweep are dropped so a sweep sees one setting
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      src_reg   <= ssq_pkg::CTRL_RST[ssq_pkg::CTRL_SRC_LO +: 2];
      res10_reg <= ssq_pkg::CTRL_RST[ssq_pkg::CTRL_RES10];
      cnt_reg   <= ssq_pkg::INSEL_RST[ssq_pkg::INSEL_CNT_LO +: 2];
      grp_reg   <= ssq_pkg::INSEL_RST[ssq_pkg::INSEL_GRP_LO +: 2];
    end else if (state_reg == ST_IDLE) begin
      if (wr_ctrl) begin
        src_reg   <= wdata_in[ssq_pkg::CTRL_SRC_LO +: 2];
        res10_reg <= wdata_in[ssq_pkg::CTRL_RES10];
      end
      if (wr_insel) begin
        cnt_reg <= wdata_in[ssq_pkg::INSEL_CNT_LO +: 2];
        grp_reg <= wdata_in[ssq_pkg::INSEL_GRP_LO +: 2];
      end
    end
  end

  // result registers, one per slot
  // an aborted conversion never lands, older slots keep stale data
  genvar gi;
  generate
    for (gi = 0; gi < ssq_pkg::NRES; gi++) begin : g_res
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          res_reg[gi] <= '0;
        // slot is input index modulo eight
        end else if (conv_done && !sw_clear && (cur_ch[2:0] == 3'(gi))) begin
          res_reg[gi] <= res_val;
        end
      end
    end
  endgenerate

  // converter request, registered
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      req_reg <= '0;
    end else begin
      req_reg.start <= launch_go;
      if (launch_go) begin
        req_reg.chan  <= cur_ch;
        req_reg.res10 <= res10_reg;
      end
    end
  end

  // sticky events and interrupt; set wins over clear
  // irq follows the status one cycle late
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      evst_reg  <= '0;
      evmsk_reg <= '0;
      irq_reg   <= 1'b0;
    end else begin
      evst_reg <= (evst_reg & ~(wr_evst ? wdata_in[ssq_pkg::EV_W-1:0] : '0)) | ev_now;
      if (wr_evmsk) begin
        evmsk_reg <= wdata_in[ssq_pkg::EV_W-1:0];
      end
      irq_reg <= |(evst_reg & evmsk_reg);
    end
  end

  // external trigger synchroniser
  // the first stage feeds no logic; the third remembers the last level for the edge
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_trig_in;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // read data one cycle after the strobe
  // zero outside the answer cycle, so the bus idles quiet
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd_in ? rd_mux : '0;
    end
  end

  // outputs come straight from the flops above
  assign rdata_out    = rdata_reg;
  assign conv_req_out = req_reg;
  assign irq_out      = irq_reg;

endmodule
`default_nettype wire

// [test/ssq_sweep_seq_assertions.sv]
// port checker for the single sweep sequencer
`timescale 1ns/1ns
`default_nettype none
module ssq_chk #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic                   clk_in,
  input wire logic                   rstn_in,
  input wire logic [ADDR_W-1:0]      addr_in,
  input wire logic [DATA_W-1:0]      wdata_in,
  input wire logic                   wr_in,
  input wire logic                   rd_in,
  input wire logic [DATA_W-1:0]      rdata_out,
  input wire logic                   tmr_a_trig_in,
  input wire logic                   tmr_b_trig_in,
  input wire logic                   ext_trig_in,
  input wire ssq_pkg::ssq_conv_req_t conv_req_out,
  input wire ssq_pkg::ssq_conv_rsp_t conv_rsp_in,
  input wire logic                   irq_out
);
  logic       st;      // start pulse to the core
  logic [5:0] ext_sh;  // recent trigger pin levels, covers sync delay
  assign st = conv_req_out.start;
  always_ff @(posedge clk_in) ext_sh <= {ext_sh[4:0], ext_trig_in};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_start_pulse: assert property (st |=> !st)
    else $error("start pulse longer than one cycle");
  a_done_gap: assert property (conv_rsp_in.done |=> !st)
    else $error("start right after done");
  a_chan_hold: assert property (!st |-> $stable(conv_req_out.chan))
    else $error("input index moved without start");
  a_res_hold: assert property (!st |-> $stable(conv_req_out.res10))
    else $error("resolution moved without start");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == '0)
    else $error("read data outside read answer");
  a_irq_rise: assert property ($rose(irq_out) |-> $past(conv_rsp_in.done, 2) || $past(wr_in, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(wr_in, 2) || !$past(rstn_in))
    else $error("interrupt fell without write");
  a_start_cause: assert property (st |-> $past(conv_rsp_in.done, 2) || $past(wr_in, 2)
    || $past(tmr_a_trig_in, 2) || $past(tmr_b_trig_in, 2) || (|ext_sh))
    else $error("start without trigger");
  c_next: cover property (conv_rsp_in.done ##2 st);
  c_irq: cover property ($rose(irq_out));
  c_tmr: cover property (tmr_b_trig_in ##2 st);
endmodule
bind ssq_sweep_seq ssq_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .tmr_a_trig_in(tmr_a_trig_in), .tmr_b_trig_in(tmr_b_trig_in), .ext_trig_in(ext_trig_in),
  .conv_req_out(conv_req_out), .conv_rsp_in(conv_rsp_in), .irq_out(irq_out));
`default_nettype wire

// [test/ssq_core_model.sv]
// converter core model answering start pulses
`timescale 1ns/1ns
`default_nettype none
module ssq_core_model (
  input  wire logic                   clk_in,
  input  wire ssq_pkg::ssq_conv_req_t req_in,
  input  wire logic [3:0]             lat_in,
  output ssq_pkg::ssq_conv_rsp_t      rsp_out
);
  logic [4:0] cnt;   // cycles left, 0 when idle
  logic [9:0] code;  // code for the input being converted
  initial begin
    cnt = 5'h0;
    code = 10'h0;
    rsp_out = '0;
  end
  // done after lat_in+1 cycles; data toggles outside done
  always @(posedge clk_in) begin
    rsp_out.done <= 1'b0;
    rsp_out.data <= ~rsp_out.data;
    if (req_in.start) begin
      cnt <= {1'b0, lat_in} + 5'h1;
      code <= {req_in.chan, req_in.chan, 2'h1};
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
      if (cnt == 5'h1) rsp_out <= {1'b1, code};
    end
  end
endmodule
`default_nettype wire

// [test/adc_single_sweep_sequencer_tb.sv]
// bench for the single sweep sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module adc_single_sweep_sequencer_tb;
  logic clk, rstn, wr, rd, ta, tb, ext, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  lat;
  ssq_pkg::ssq_conv_req_t req;
  ssq_pkg::ssq_conv_rsp_t rsp;
  int miscompares, total_checks, nseen;
  int seen [16];  // input order seen at the core
  logic [7:0] cfg [9] = '{8'h01, 8'h49, 8'h11, 8'h59, 8'h21, 8'h39, 8'h13, 8'h15, 8'h1F};
  ssq_sweep_seq u_ssq_sweep_seq (.clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .tmr_a_trig_in(ta), .tmr_b_trig_in(tb),
    .ext_trig_in(ext), .conv_req_out(req), .conv_rsp_in(rsp), .irq_out(irq));
  ssq_core_model u_ssq_core_model (.clk_in(clk), .req_in(req), .lat_in(lat), .rsp_out(rsp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // record each start the core receives
  always @(posedge clk) if (req.start === 1'b1) begin
    seen[nseen % 16] = int'(req.chan);
    nseen++;
  end
  task automatic stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic wait_irq;
    int k;
    for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    if (irq !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: no interrupt", $time);
      stop_test();
    end
  endtask
  // one sweep: cfg byte is {group/count, control}
  task automatic sweep(input logic [7:0] c);
    int n, b, i;
    n = 2 * (int'(c[5:4]) + 1);
    b = (c[6] && c[5:4] < 2) ? 8 : 0;
    nseen = 0;
    wr_reg(ssq_pkg::OFF_INSEL, {28'h0, c[7:4]});
    wr_reg(ssq_pkg::OFF_CTRL, {28'h0, c[3:0]});
    if (c[2:1] == 2'h1) begin ta <= 1'b1; @(posedge clk); ta <= 1'b0; end
    if (c[2:1] == 2'h2) begin tb <= 1'b1; @(posedge clk); tb <= 1'b0; end
    if (c[2:1] == 2'h3) begin ext <= 1'b1; repeat (8) @(posedge clk); ext <= 1'b0; end
    wait_irq();
    `CHK(nseen, n)
    `CHK(req.res10, c[3])
    for (i = 0; i < n; i++) `CHK(seen[i], b + i)
    for (i = 0; i < n; i++) rd_reg(ssq_pkg::OFF_RES0 + 8'(4 * ((b + i) % 8)),
      c[3] ? {22'h0, 4'(b + i), 4'(b + i), 2'h1} : {24'h0, 4'(b + i), 4'(b + i)});
    rd_reg(ssq_pkg::OFF_CTRL, {28'h0, c[3:1], c[2:1] != 2'h0});
    rd_reg(ssq_pkg::OFF_IRQST, 32'h0000_0001);
    wr_reg(ssq_pkg::OFF_CTRL, {28'h0, c[3:1], 1'b0});
    rd_reg(ssq_pkg::OFF_STATE, 32'h0000_0001);
    wr_reg(ssq_pkg::OFF_IRQST, 32'h0000_0001);
    @(posedge clk); #1 `CHK(irq, 1'b0)
  endtask
  initial begin
    {rstn, wr, rd, ta, tb, ext} = 6'h0;
    {addr, wdata, lat, miscompares, total_checks, nseen} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(ssq_pkg::OFF_CTRL, 32'h0);
    rd_reg(ssq_pkg::OFF_IRQMSK, 32'h0);
    rd_reg(ssq_pkg::OFF_STATE, 32'h0000_0001);
    rd_reg(8'h14, 32'h0);
    wr_reg(ssq_pkg::OFF_IRQMSK, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      lat <= 4'(i * 2);
      sweep(cfg[i]);
    end
    // abort mid sweep with the abort event masked
    wr_reg(ssq_pkg::OFF_INSEL, 32'h0000_0003);
    wr_reg(ssq_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (5) @(posedge clk);
    wr_reg(ssq_pkg::OFF_CTRL, 32'h0);
    repeat (60) @(posedge clk);
    #1 `CHK(irq, 1'b0)
    rd_reg(ssq_pkg::OFF_IRQST, 32'h0000_0002);
    rd_reg(ssq_pkg::OFF_STATE, 32'h0000_0001);
    wr_reg(ssq_pkg::OFF_IRQMSK, 32'h0000_0003);
    @(posedge clk); #1 `CHK(irq, 1'b1)
    stop_test();
  end
endmodule
`default_nettype wire
